/* src/ddio_fifo.sv */
// Purpose: Value and time stamp FIFO for sampled channel words
// Assumes: One clock, synchronous push and pop
// Notes: Full refuses push, empty refuses pop
`timescale 1ns/100ps
`default_nettype none
module ddio_fifo #(
  parameter int unsigned DW = 64,
  parameter int unsigned DEPTH = 511
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_push,
  input wire logic [DW-1:0] i_data,
  output logic o_full,
  input wire logic i_pop,
  output logic [DW-1:0] o_data,
  output logic o_empty
);
  localparam int unsigned AW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW-1:0] DEPTH_C = AW'(DEPTH);
  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d, cnt_q, cnt_d;
  logic do_push, do_pop;

  ////////////////////////////////////////////////////////////////
  // Pointer and count updates
  always_comb
  begin
    do_push = i_push && (cnt_q != DEPTH_C);
    do_pop = i_pop && (cnt_q != '0);
    wr_d = do_push ? ((wr_q == LAST) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = do_pop ? ((rd_q == LAST) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + AW'(do_push) - AW'(do_pop);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset, so it maps to RAM
  always_ff @(posedge i_clk)
  begin
    if (do_push)
      mem[wr_q] <= i_data;
  end

  assign o_data = mem[rd_q];
  assign o_full = (cnt_q == DEPTH_C);
  assign o_empty = (cnt_q == '0);
endmodule
`default_nettype wire

/* src/ddio_pkg.sv */
// Purpose: Shared constants for the differential digital I/O port
// Assumes: 32-bit channel word, 20 MHz system clock
// Notes: Bit layout and mode codes are used by the port; the FIFO only takes its depth from here
package ddio_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned TTL_N = 8;
  localparam int unsigned DIFF_N = 12;
  localparam int unsigned DIFF_SPI_N = 4;
  localparam int unsigned TTL_GRP_W = 4;
  localparam int unsigned TTL_GRP_N = 2;
  localparam int unsigned DIFF_LSB = 0;
  localparam int unsigned TTL_LO_LSB = 16;
  localparam int unsigned TTL_HI_LSB = 24;
  localparam logic [31:0] USED_MASK = 32'h0F0F0FFF;
  localparam logic [11:0] DIFF_SPI_MASK = 12'h00F;
  localparam int unsigned FIFO_DEPTH = 511;
  localparam int unsigned STAMP_W = 32;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned SAMPLE_HZ = 100000000;
  localparam logic [1:0] MODE_DIGITAL = 2'h3;
  localparam logic [11:0] DIFF_DIR_RST = 12'h000;
  localparam logic [1:0] TTL_DIR_RST = 2'h0;
  localparam logic [31:0] WORD_RST = 32'h00000000;
endpackage

/* src/ddio_port.sv */
// Purpose: Digital channel port of the differential two-interface I/O module
// Assumes: Inputs synchronous to i_clk; host strobes are one-cycle pulses
// Notes: Sampling runs every cycle here; the 100 MHz figure scales the stamp
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [RULE1] In digital mode all 8 TTL and all 12 differential channels are usable.
// [RULE2] In any SPI mode only the 8 TTL and the lowest 4 differential channels are usable.
// [RULE3] TTL direction is set per group of four adjacent channels.
// [RULE4] Each differential channel has its own direction bit.
// [RULE5] After reset every channel is an input.
// [RULE6] Output word bits 0-11 drive differential, 16-19 and 24-27 drive TTL channels.
// [RULE7] An output write affects only channels set as outputs.
// [RULE8] Bits 12-15, 20-23 and 28-31 drive nothing.
// [RULE9] Pin roles follow the selected operation mode.
// [RULE10] Input and output FIFOs hold 511 value and stamp pairs.
// [RULE11] Digital mode disables both SPI interfaces.
// [RULE12] An enabled event edge requests an immediate process cycle.
// [RULE13] An input read returns channel states at output bit positions, zero elsewhere.
// [RULE14] Read back of the output word returns the last written value for output channels.
module ddio_port #(
  parameter int unsigned DEPTH = ddio_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_operation_mode_select,
  input wire logic i_ttl_dir_wr,
  input wire logic [1:0] i_ttl_group_direction_config,
  input wire logic i_diff_dir_wr,
  input wire logic [11:0] i_diff_channel_direction_config,
  input wire logic i_write_output_word,
  input wire logic [31:0] i_out_word,
  input wire logic [7:0] i_ttl_pin,
  input wire logic [11:0] i_diff_pin,
  input wire logic i_event_pin,
  input wire logic i_event_enable,
  input wire logic i_in_fifo_enable,
  input wire logic i_in_fifo_pop,
  input wire logic i_out_fifo_push,
  input wire logic [31:0] i_out_fifo_value,
  input wire logic [31:0] i_out_fifo_stamp,
  output logic [31:0] o_read_input_word,
  output logic [31:0] o_read_back_output_word,
  output logic [7:0] o_ttl_out,
  output logic [7:0] o_ttl_oe,
  output logic [11:0] o_diff_out,
  output logic [11:0] o_diff_oe,
  output logic o_spi_enable,
  output logic o_process_request,
  output logic [63:0] o_in_fifo_data,
  output logic o_in_fifo_empty,
  output logic o_in_fifo_full,
  output logic o_out_fifo_full,
  output logic o_out_fifo_empty
);
  localparam logic [31:0] STAMP_STEP = 32'(ddio_pkg::SAMPLE_HZ / ddio_pkg::CLK_HZ);
  logic [1:0] ttl_dir_q, ttl_dir_d;
  logic [11:0] diff_dir_q, diff_dir_d;
  logic [31:0] out_q, out_d, in_q, in_d, rb_q, rb_d;
  logic [7:0] ttl_oe_d, ttl_out_q, ttl_oe_q;
  logic [11:0] diff_mask, diff_oe_d, diff_out_q, diff_oe_q;
  logic [31:0] pin_word, stamp_q, stamp_d, prev_in_q;
  logic digital_mode, ev_q, ev_d, req_q, req_d, spi_q, spi_d;
  logic in_push, in_full, in_empty, out_full, out_empty, out_pop;
  logic [63:0] in_data, out_data;

  ////////////////////////////////////////////////////////////////
  // Mode gating of usable channels
  assign digital_mode = (i_operation_mode_select == ddio_pkg::MODE_DIGITAL); // [RULE9]
  // SPI modes keep the upper differential pins for the engines
  assign diff_mask = digital_mode ? '1 : ddio_pkg::DIFF_SPI_MASK; // [RULE1] [RULE2]

  // Per-group TTL enables, per-bit differential enables
  genvar g;
  generate
    for (g = 0; g < ddio_pkg::TTL_N; g++)
    begin : g_ttl
      assign ttl_oe_d[g] = ttl_dir_q[g / ddio_pkg::TTL_GRP_W]; // [RULE3]
    end
  endgenerate
  assign diff_oe_d = diff_dir_q & diff_mask; // [RULE4] [RULE2]

  // Pins gathered into the channel word; unused bits stay zero
  assign pin_word = {4'h0, i_ttl_pin[7:4], 4'h0, i_ttl_pin[3:0], 4'h0,
                     i_diff_pin & diff_mask}; // [RULE13] [RULE8]

  ////////////////////////////////////////////////////////////////
  // Next-state of configuration, data and event logic
  always_comb
  begin
    ttl_dir_d = i_ttl_dir_wr ? i_ttl_group_direction_config : ttl_dir_q; // [RULE3]
    diff_dir_d = i_diff_dir_wr ? i_diff_channel_direction_config : diff_dir_q; // [RULE4]
    out_d = out_q;
    if (i_write_output_word)
      out_d = i_out_word & ddio_pkg::USED_MASK; // [RULE8]
    else if (out_pop)
      out_d = out_data[63:32] & ddio_pkg::USED_MASK;
    in_d = pin_word; // [RULE13]
    rb_d = out_q; // [RULE14]
    stamp_d = stamp_q + STAMP_STEP; // [RULE10]
    ev_d = i_event_pin;
    req_d = i_event_enable && i_event_pin && !ev_q; // [RULE12]
    spi_d = !digital_mode; // [RULE11]
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ttl_dir_q <= ddio_pkg::TTL_DIR_RST; // [RULE5]
      diff_dir_q <= ddio_pkg::DIFF_DIR_RST; // [RULE5]
      out_q <= ddio_pkg::WORD_RST;
      in_q <= ddio_pkg::WORD_RST;
      rb_q <= ddio_pkg::WORD_RST;
      prev_in_q <= ddio_pkg::WORD_RST;
      stamp_q <= '0;
      ev_q <= 1'b0;
      req_q <= 1'b0;
      spi_q <= 1'b1;
      ttl_out_q <= '0;
      ttl_oe_q <= '0;
      diff_out_q <= '0;
      diff_oe_q <= '0;
    end
    else
    begin
      ttl_dir_q <= ttl_dir_d;
      diff_dir_q <= diff_dir_d;
      out_q <= out_d;
      in_q <= in_d;
      rb_q <= rb_d;
      prev_in_q <= in_q;
      stamp_q <= stamp_d;
      ev_q <= ev_d;
      req_q <= req_d;
      spi_q <= spi_d;
      // Pin values follow the latch; enables gate what reaches the pins
      ttl_out_q <= {out_q[ddio_pkg::TTL_HI_LSB +: 4], out_q[ddio_pkg::TTL_LO_LSB +: 4]}; // [RULE6]
      diff_out_q <= out_q[ddio_pkg::DIFF_LSB +: 12]; // [RULE6]
      ttl_oe_q <= ttl_oe_d; // [RULE7]
      diff_oe_q <= diff_oe_d; // [RULE7]
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sample FIFO: pushes on input change; output FIFO feeds the latch
  assign in_push = i_in_fifo_enable && (in_q != prev_in_q);
  assign out_pop = !out_empty && !i_write_output_word && (out_data[31:0] == stamp_q);

  ddio_fifo #(.DW(64), .DEPTH(DEPTH)) u_in_fifo ( // [RULE10]
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_push(in_push),
    .i_data({in_q, stamp_q}),
    .o_full(in_full),
    .i_pop(i_in_fifo_pop),
    .o_data(in_data),
    .o_empty(in_empty)
  );

  ddio_fifo #(.DW(64), .DEPTH(DEPTH)) u_out_fifo ( // [RULE10]
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_push(i_out_fifo_push),
    .i_data({i_out_fifo_value, i_out_fifo_stamp}),
    .o_full(out_full),
    .i_pop(out_pop),
    .o_data(out_data),
    .o_empty(out_empty)
  );

  // FIFO status registered so every output is a flop
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_in_fifo_data <= '0;
      o_in_fifo_empty <= 1'b1;
      o_in_fifo_full <= 1'b0;
      o_out_fifo_full <= 1'b0;
      o_out_fifo_empty <= 1'b1;
    end
    else
    begin
      o_in_fifo_data <= in_data;
      o_in_fifo_empty <= in_empty;
      o_in_fifo_full <= in_full;
      o_out_fifo_full <= out_full;
      o_out_fifo_empty <= out_empty;
    end
  end

  assign o_read_input_word = in_q;
  assign o_read_back_output_word = rb_q;
  assign o_ttl_out = ttl_out_q;
  assign o_ttl_oe = ttl_oe_q;
  assign o_diff_out = diff_out_q;
  assign o_diff_oe = diff_oe_q;
  assign o_spi_enable = spi_q;
  assign o_process_request = req_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  sequence s_write;
    i_write_output_word;
  endsequence

  unused_bits_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE8]
    (out_q & ~ddio_pkg::USED_MASK) == '0) else $error("unused bits set");
  spi_mask_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE2]
    !digital_mode |-> ##2 (o_diff_oe[11:4] == '0 || $past(digital_mode))) else $error("spi oe");
  group_dir_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE3]
    o_ttl_oe == {{4{$past(ttl_dir_q[1])}}, {4{$past(ttl_dir_q[0])}}}) else $error("group dir");
  diff_dir_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE4]
    digital_mode && i_diff_dir_wr |=> ##1 o_diff_oe == $past(i_diff_channel_direction_config, 2)
    || !$past(digital_mode)) else $error("diff dir");
  write_map_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE6]
    s_write |=> ##1 o_diff_out == $past(i_out_word[11:0], 2)) else $error("out map");
  readback_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE14]
    s_write ##1 !i_write_output_word |=>
    o_read_back_output_word == ($past(i_out_word, 2) & ddio_pkg::USED_MASK))
    else $error("read back");
  input_word_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE13]
    (o_read_input_word & ~ddio_pkg::USED_MASK) == '0) else $error("input bits");
  spi_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE11]
    digital_mode |=> !o_spi_enable) else $error("spi not off");
  event_req_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE12]
    i_event_enable && $rose(i_event_pin) |=> o_process_request ##1 !o_process_request)
    else $error("event");
endmodule
`default_nettype wire

/* tb/ddio_lines.sv */
// Purpose: Model of the external wiring on the channel pins
// Assumes: Far side drives every channel that the port leaves as input
// Notes: A driven channel reads back the port's own level
`timescale 1ns/100ps
`default_nettype none
module ddio_lines (
  input wire logic [7:0] i_ttl_out,
  input wire logic [7:0] i_ttl_oe,
  input wire logic [11:0] i_diff_out,
  input wire logic [11:0] i_diff_oe,
  input wire logic [7:0] i_ttl_ext,
  input wire logic [11:0] i_diff_ext,
  output logic [7:0] o_ttl_pin,
  output logic [11:0] o_diff_pin
);
  // Wire level per bit; port drive wins where enabled, so no fight is modelled
  assign o_ttl_pin = (i_ttl_oe & i_ttl_out) | (~i_ttl_oe & i_ttl_ext);
  assign o_diff_pin = (i_diff_oe & i_diff_out) | (~i_diff_oe & i_diff_ext);
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the digital channel port
// Assumes: 20 MHz clock, inputs driven by non-blocking assignment at rising edges
// Notes: Direction, output, input, FIFO, event and mid-run reset paths exercised
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic i_clk, i_sys_rst, tw, dw, ww, ev, ev_en;
  logic [1:0] mode, tcfg;
  logic [11:0] dcfg, dext, dpin, dout, doe;
  logic [31:0] word, rin, rback;
  logic [7:0] text, tpin, tout, toe;
  logic spi_en, preq;
  logic fen, fpop, opush, fempty, ffull, oempty, ofull;
  logic [31:0] oval, ostamp;
  logic [63:0] fdata;
  int n_mismatch, n_tests, cycles;
  // Stamp ticks per system clock, from the 100 MHz stamp rate
  localparam int STEP = ddio_pkg::SAMPLE_HZ / ddio_pkg::CLK_HZ;
  ddio_port u_ddio_port (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_operation_mode_select(mode),
    .i_ttl_dir_wr(tw), .i_ttl_group_direction_config(tcfg), .i_diff_dir_wr(dw),
    .i_diff_channel_direction_config(dcfg), .i_write_output_word(ww), .i_out_word(word),
    .i_ttl_pin(tpin), .i_diff_pin(dpin), .i_event_pin(ev), .i_event_enable(ev_en),
    .i_in_fifo_enable(fen), .i_in_fifo_pop(fpop), .i_out_fifo_push(opush),
    .i_out_fifo_value(oval), .i_out_fifo_stamp(ostamp),
    .o_read_input_word(rin), .o_read_back_output_word(rback), .o_ttl_out(tout), .o_ttl_oe(toe),
    .o_diff_out(dout), .o_diff_oe(doe), .o_spi_enable(spi_en), .o_process_request(preq),
    .o_in_fifo_data(fdata), .o_in_fifo_empty(fempty), .o_in_fifo_full(ffull),
    .o_out_fifo_full(ofull), .o_out_fifo_empty(oempty));
  ddio_lines u_ddio_lines (.i_ttl_out(tout), .i_ttl_oe(toe), .i_diff_out(dout),
    .i_diff_oe(doe), .i_ttl_ext(text), .i_diff_ext(dext), .o_ttl_pin(tpin), .o_diff_pin(dpin));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the ceiling is well above the roughly 2150 cycles used
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic set_dir(input logic [1:0] t, input logic [11:0] d);
    @(posedge i_clk);
    tw <= 1'b1;
    dw <= 1'b1;
    tcfg <= t;
    dcfg <= d;
    @(posedge i_clk);
    tw <= 1'b0;
    dw <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic put_word(input logic [31:0] w);
    @(posedge i_clk);
    ww <= 1'b1;
    word <= w;
    @(posedge i_clk);
    ww <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    @(negedge i_clk);
    chk("ttl_oe", toe, 32'h0);
    chk("diff_oe", doe, 32'h0);
    chk("readback", rback, 32'h0);
    chk("in fifo empty", fempty, 32'h1);
    chk("out fifo empty", oempty, 32'h1);
  endtask
  task automatic t_modes;
    set_dir(2'h3, 12'hFFF);
    chk("spi diff_oe", doe, 32'h00F);
    chk("spi enable", spi_en, 32'h1);
    @(posedge i_clk);
    mode <= ddio_pkg::MODE_DIGITAL;
    repeat (4) @(posedge i_clk);
    chk("dig diff_oe", doe, 32'hFFF);
    chk("dig ttl_oe", toe, 32'hFF);
    chk("dig spi off", spi_en, 32'h0);
  endtask
  task automatic t_output;
    set_dir(2'h1, 12'hA5C);
    chk("grp ttl_oe", toe, 32'h0F);
    chk("own diff_oe", doe, 32'hA5C);
    put_word(32'hFFFFFFFF);
    chk("ttl drive", tpin, 32'h0F);
    chk("diff drive", dpin, 32'hA5C);
    chk("readback mask", rback, 32'h0F0F0FFF);
    set_dir(2'h2, 12'hFFF);
    put_word(32'h0A050123);
    chk("ttl map", tout & toe, 32'hA0);
    chk("diff map", dout & doe, 32'h123);
    chk("readback", rback, 32'h0A050123);
  endtask
  task automatic t_input;
    set_dir(2'h0, 12'h000);
    @(posedge i_clk);
    text <= 8'h3C;
    dext <= 12'h9A6;
    repeat (3) @(posedge i_clk);
    chk("input word", rin, 32'h030C09A6);
  endtask
  // Log every input change, overrun by one, then drain and check order and stamps
  task automatic t_in_fifo;
    logic [31:0] last;
    last = 32'h0;
    @(posedge i_clk);
    fen <= 1'b1;
    for (int i = 0; i <= ddio_pkg::FIFO_DEPTH; i++)
    begin
      @(posedge i_clk);
      dext <= 12'(i);
    end
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    chk("in fifo full", ffull, 32'h1);
    chk("in fifo filled", fempty, 32'h0);
    for (int i = 0; i < ddio_pkg::FIFO_DEPTH; i++)
    begin
      chk("in fifo value", fdata[63:32], 32'h030C0000 | 32'(i));
      if (i > 0)
        chk("in fifo stamp step", fdata[31:0] - last, 32'(STEP));
      last = fdata[31:0];
      @(posedge i_clk);
      fpop <= 1'b1;
      @(posedge i_clk);
      fpop <= 1'b0;
      // Status and head data are registered, so wait one edge more
      repeat (2) @(negedge i_clk);
    end
    chk("in fifo drained", fempty, 32'h1);
    chk("in fifo not full", ffull, 32'h0);
    @(posedge i_clk);
    fen <= 1'b0;
  endtask
  task automatic t_event(input logic en, input int exp);
    int seen;
    seen = 0;
    @(posedge i_clk);
    ev_en <= en;
    ev <= 1'b1;
    repeat (6)
    begin
      @(posedge i_clk);
      #1 seen += (preq === 1'b1);
    end
    @(posedge i_clk);
    ev <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("event pulses", seen, exp);
  endtask
  // Mid-run reset, then two timed output words released by the stamp
  task automatic t_restart;
    set_dir(2'h3, 12'hFFF);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    chk("restart ttl_oe", toe, 32'h0);
    chk("restart diff_oe", doe, 32'h0);
    @(posedge i_clk);
    opush <= 1'b1;
    oval <= 32'h0C0300A5;
    ostamp <= 32'(STEP * 20);
    @(posedge i_clk);
    oval <= 32'hF3FCF5A6;
    ostamp <= 32'(STEP * 30);
    @(posedge i_clk);
    opush <= 1'b0;
    // Stamp counts from zero at release, so the first pop is 21 edges on
    repeat (18) @(posedge i_clk);
    @(negedge i_clk);
    chk("timed word early", rback, 32'h0);
    chk("out fifo not full", ofull, 32'h0);
    chk("out fifo pending", oempty, 32'h0);
    @(negedge i_clk);
    chk("timed word", rback, 32'h0C0300A5);
    chk("timed diff", dout, 32'h0A5);
    repeat (9) @(posedge i_clk);
    @(negedge i_clk);
    chk("second word early", rback, 32'h0C0300A5);
    @(negedge i_clk);
    chk("second word", rback, 32'h030C05A6);
    chk("out fifo drained", oempty, 32'h1);
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; reset held two cycles, SPI mode 0 at start
  initial
  begin
    {tw, dw, ww, ev, ev_en, tcfg, dcfg, word} = '0;
    {fen, fpop, opush, oval, ostamp} = '0;
    mode = 2'h0;
    text = 8'h00;
    dext = 12'h000;
    n_mismatch = 0;
    n_tests = 0;
    cycles = 0;
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    t_reset();
    t_modes();
    t_output();
    t_input();
    t_in_fifo();
    t_event(1'b1, 1);
    t_event(1'b0, 0);
    t_restart();
    final_report();
  end
endmodule
`default_nettype wire
